// ### design/cniu_consts.svh
// constants for the can node interrupt unit: register offsets, field positions, limits
`ifndef CNIU_CONSTS_SVH
`define CNIU_CONSTS_SVH

// ************************************************************
// register offsets (plain register port, 8-bit address)
// ************************************************************
`define CNIU_OFS_ENABLE 8'h2b
`define CNIU_OFS_FLAG 8'h2c
`define CNIU_OFS_FAULT 8'h2d
`define CNIU_OFS_STATUS 8'h0e
`define CNIU_OFS_TXCNT 8'h1c
`define CNIU_OFS_RXCNT 8'h1d
`define CNIU_OFS_CTRL 8'h0f

// ************************************************************
// flag and enable bit positions
// ************************************************************
`define CNIU_BIT_RX0 0
`define CNIU_BIT_RX1 1
`define CNIU_BIT_TX0 2
`define CNIU_BIT_TX1 3
`define CNIU_BIT_TX2 4
`define CNIU_BIT_ERR 5
`define CNIU_BIT_WAK 6
`define CNIU_BIT_MERR 7

// ************************************************************
// fault state register bit positions
// ************************************************************
`define CNIU_FS_EWARN 0
`define CNIU_FS_RXWAR 1
`define CNIU_FS_TXWAR 2
`define CNIU_FS_RXEP 3
`define CNIU_FS_TXEP 4
`define CNIU_FS_TXBO 5
`define CNIU_FS_RX0OV 6
`define CNIU_FS_RX1OV 7

// ************************************************************
// reset values and counter limits
// ************************************************************
`define CNIU_RST_BYTE 8'h00
`define CNIU_WARN_LIMIT 9'h060
`define CNIU_PASSIVE_LIMIT 9'h07f
`define CNIU_BUSOFF_LIMIT 9'h0ff

// ************************************************************
// source codes, lower value wins
// ************************************************************
`define CNIU_CODE_NONE 3'h0
`define CNIU_CODE_ERR 3'h1
`define CNIU_CODE_WAK 3'h2
`define CNIU_CODE_TX0 3'h3
`define CNIU_CODE_TX1 3'h4
`define CNIU_CODE_TX2 3'h5
`define CNIU_CODE_RX0 3'h6
`define CNIU_CODE_RX1 3'h7

`endif

// ### design/cniu_pkg.sv
// types shared by the can node interrupt unit
package cniu_pkg;

  // ************************************************************
  // register port request
  // ************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cniu_bus_req_t;

  // ************************************************************
  // hardware event pulses from the protocol engine
  // ************************************************************
  typedef struct packed {
    logic [2:0] tx_empty;
    logic [1:0] rx_loaded;
    logic [1:0] rx_overrun;
    logic msg_fault;
    logic bus_activity;
  } cniu_events_t;

  // ************************************************************
  // conditions that still prevail, blocking a clear
  // ************************************************************
  typedef struct packed {
    logic [2:0] tx_empty;
    logic [1:0] rx_loaded;
  } cniu_hold_t;

  typedef enum logic [1:0] {
    CNIU_SLEEP_IDLE = 2'b00,
    CNIU_SLEEP_ASLEEP = 2'b01,
    CNIU_SLEEP_WAKING = 2'b10
  } cniu_sleep_t;

endpackage : cniu_pkg

// ### design/cniu_fault_state.sv
// fault state evaluation from the two error counters
`timescale 1ns/10ps
`include "cniu_consts.svh"

module cniu_fault_state (
  input wire logic clk, // device clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic [8:0] tx_err_count, // transmit error counter
  input wire logic [8:0] rx_err_count, // receive error counter
  output logic [5:0] state_reg, // busoff, txep, rxep, txwar, rxwar, ewarn
  output logic changed // one-cycle pulse on any state change
);
  logic [5:0] state_next;

  always_comb begin
    state_next[`CNIU_FS_RXWAR] = rx_err_count >= `CNIU_WARN_LIMIT;
    state_next[`CNIU_FS_TXWAR] = tx_err_count >= `CNIU_WARN_LIMIT;
    state_next[`CNIU_FS_EWARN] = state_next[`CNIU_FS_RXWAR] | state_next[`CNIU_FS_TXWAR];
    state_next[`CNIU_FS_RXEP] = rx_err_count > `CNIU_PASSIVE_LIMIT;
    state_next[`CNIU_FS_TXEP] = tx_err_count > `CNIU_PASSIVE_LIMIT;
    state_next[`CNIU_FS_TXBO] = tx_err_count > `CNIU_BUSOFF_LIMIT;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= 6'h00;
      changed <= 1'b0;
    end else begin
      state_reg <= state_next;
      changed <= state_next != state_reg;
    end
  end

endmodule : cniu_fault_state

// ### design/cniu_top.sv
// interrupt aggregation for the can node: flags, enables, priority code, pin
`timescale 1ns/10ps
`include "cniu_consts.svh"

module cniu_top
  import cniu_pkg::*;
(
  input wire logic clk, // device clock, 100 mhz
  input wire logic reset_n, // synchronous reset, active low
  input cniu_pkg::cniu_bus_req_t bus_req, // register port request
  output logic [7:0] rd_data, // read data, cycle after the read strobe
  input cniu_pkg::cniu_events_t events, // event pulses from the engine
  input cniu_pkg::cniu_hold_t hold, // conditions still prevailing
  input wire logic [8:0] tx_err_count, // transmit error counter
  input wire logic [8:0] rx_err_count, // receive error counter
  input wire logic sleep_request, // engine asks to enter sleep
  output logic sleeping, // device is in sleep mode
  output logic irq_n, // interrupt pin, active low
  output logic [2:0] irq_source_code // highest-priority pending source
);
  import cniu_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_flag_reg;
  logic [7:0] irq_flag_next;
  logic [1:0] rx_overrun_flag;
  logic [7:0] ctrl_status_reg;
  logic [7:0] fault_state_reg;
  logic [5:0] fs_level;
  logic fs_changed;
  logic irq_n_reg;
  logic [2:0] code_reg;
  cniu_sleep_t sleep_reg;
  logic [7:0] hw_set;
  logic [7:0] hold_mask;
  logic wr_enable;
  logic wr_flag;
  logic wr_fault;

  // ************************************************************
  // priority encoder used for the code field
  // ************************************************************
  function automatic logic [2:0] cniu_encode(input logic [7:0] act);
    logic [2:0] c;
    c = `CNIU_CODE_NONE;
    if (act[`CNIU_BIT_ERR]) c = `CNIU_CODE_ERR;
    else if (act[`CNIU_BIT_WAK]) c = `CNIU_CODE_WAK;
    else if (act[`CNIU_BIT_TX0]) c = `CNIU_CODE_TX0;
    else if (act[`CNIU_BIT_TX1]) c = `CNIU_CODE_TX1;
    else if (act[`CNIU_BIT_TX2]) c = `CNIU_CODE_TX2;
    else if (act[`CNIU_BIT_RX0]) c = `CNIU_CODE_RX0;
    else if (act[`CNIU_BIT_RX1]) c = `CNIU_CODE_RX1;
    return c;
  endfunction : cniu_encode

  cniu_fault_state u_fault_state (
    .clk(clk),
    .reset_n(reset_n),
    .tx_err_count(tx_err_count),
    .rx_err_count(rx_err_count),
    .state_reg(fs_level),
    .changed(fs_changed)
  );

  assign wr_enable = bus_req.wr && bus_req.addr == `CNIU_OFS_ENABLE;
  assign wr_flag = bus_req.wr && bus_req.addr == `CNIU_OFS_FLAG;
  assign wr_fault = bus_req.wr && bus_req.addr == `CNIU_OFS_FAULT;

  // ************************************************************
  // hardware set terms and clear blocking
  // ************************************************************
  always_comb begin
    hw_set = 8'h00;
    hw_set[`CNIU_BIT_TX0] = events.tx_empty[0];
    hw_set[`CNIU_BIT_TX1] = events.tx_empty[1];
    hw_set[`CNIU_BIT_TX2] = events.tx_empty[2];
    hw_set[`CNIU_BIT_RX0] = events.rx_loaded[0];
    hw_set[`CNIU_BIT_RX1] = events.rx_loaded[1];
    hw_set[`CNIU_BIT_MERR] = events.msg_fault;
    // wake counts only while asleep with its enable set
    hw_set[`CNIU_BIT_WAK] = events.bus_activity && sleep_reg == CNIU_SLEEP_ASLEEP
                            && irq_enable_reg[`CNIU_BIT_WAK];
    hw_set[`CNIU_BIT_ERR] = fs_changed || (|events.rx_overrun);
    hold_mask = 8'h00;
    hold_mask[`CNIU_BIT_TX0] = hold.tx_empty[0];
    hold_mask[`CNIU_BIT_TX1] = hold.tx_empty[1];
    hold_mask[`CNIU_BIT_TX2] = hold.tx_empty[2];
    hold_mask[`CNIU_BIT_RX0] = hold.rx_loaded[0];
    hold_mask[`CNIU_BIT_RX1] = hold.rx_loaded[1];
    hold_mask[`CNIU_BIT_ERR] = |rx_overrun_flag;
  end

  // ************************************************************
  // flag register: host writes both ways, hardware set wins
  // ************************************************************
  always_comb begin
    irq_flag_next = irq_flag_reg;
    if (wr_flag) begin
      // a host-set flag raises an interrupt like any other
      irq_flag_next = bus_req.wdata | (irq_flag_reg & hold_mask);
    end
    irq_flag_next = irq_flag_next | hw_set;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_flag_reg <= `CNIU_RST_BYTE;
    end else begin
      irq_flag_reg <= irq_flag_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_enable_reg <= `CNIU_RST_BYTE;
    end else if (wr_enable) begin
      irq_enable_reg <= bus_req.wdata;
    end
  end

  // ************************************************************
  // overflow flags: host may only clear, set wins
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_overrun_flag <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (events.rx_overrun[i]) begin
          rx_overrun_flag[i] <= 1'b1;
        end else if (wr_fault && !bus_req.wdata[`CNIU_FS_RX0OV + i]) begin
          rx_overrun_flag[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    fault_state_reg = {rx_overrun_flag[1], rx_overrun_flag[0], fs_level};
  end

  // ************************************************************
  // sleep handling
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sleep_reg <= CNIU_SLEEP_IDLE;
    end else begin
      case (sleep_reg)
        CNIU_SLEEP_IDLE: begin
          if (sleep_request) begin
            sleep_reg <= CNIU_SLEEP_ASLEEP;
          end
        end
        CNIU_SLEEP_ASLEEP: begin
          if (hw_set[`CNIU_BIT_WAK]) begin
            sleep_reg <= CNIU_SLEEP_WAKING;
          end
        end
        CNIU_SLEEP_WAKING: begin
          sleep_reg <= CNIU_SLEEP_IDLE;
        end
        default: begin
          sleep_reg <= CNIU_SLEEP_IDLE;
        end
      endcase
    end
  end

  assign sleeping = sleep_reg == CNIU_SLEEP_ASLEEP;

  // ************************************************************
  // pin and code, both from the same registered flags
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_n_reg <= 1'b1;
      code_reg <= `CNIU_CODE_NONE;
    end else begin
      irq_n_reg <= ~|(irq_flag_reg & irq_enable_reg);
      code_reg <= cniu_encode(irq_flag_reg & irq_enable_reg);
    end
  end

  assign irq_n = irq_n_reg;
  assign irq_source_code = code_reg;

  always_comb begin
    ctrl_status_reg = {code_reg, 5'h00};
    if (sleep_reg == CNIU_SLEEP_ASLEEP) begin
      ctrl_status_reg[0] = 1'b1;
    end
  end

  // ************************************************************
  // register read port; unmapped addresses read zero
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `CNIU_OFS_ENABLE: rd_data <= irq_enable_reg;
        `CNIU_OFS_FLAG: rd_data <= irq_flag_reg;
        `CNIU_OFS_FAULT: rd_data <= fault_state_reg;
        `CNIU_OFS_STATUS: rd_data <= ctrl_status_reg;
        `CNIU_OFS_TXCNT: rd_data <= tx_err_count[7:0];
        `CNIU_OFS_RXCNT: rd_data <= rx_err_count[7:0];
        default: rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

endmodule : cniu_top

// ### verification/cniu_top_sva.sv
// assertions on the pins and register port of the can node interrupt unit
`timescale 1ns/10ps
`include "cniu_consts.svh"

module cniu_top_sva
  import cniu_pkg::*;
(
  input wire logic clk, // device clock
  input wire logic reset_n, // synchronous reset, active low
  input cniu_pkg::cniu_bus_req_t bus_req, // register port request
  input wire logic [7:0] rd_data, // read data
  input cniu_pkg::cniu_events_t events, // engine event pulses
  input wire logic sleeping, // sleep mode
  input wire logic irq_n, // interrupt pin
  input wire logic [2:0] irq_source_code // source code
);
  import cniu_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ********
  // shadow of the enable register, seen from the port
  // ********
  logic [7:0] en_q;
  always_ff @(posedge clk) begin
    if (!reset_n)
      en_q <= 8'h00;
    else if (bus_req.wr && bus_req.addr == `CNIU_OFS_ENABLE)
      en_q <= bus_req.wdata;
  end
  AST_RD_IDLE: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
    else $error("read data not zero outside the answer cycle");
  AST_RD_EN: assert property (bus_req.rd && bus_req.addr == `CNIU_OFS_ENABLE
    |=> rd_data == en_q)
    else $error("enable read back wrong");
  AST_CODE_IRQ: assert property (irq_source_code != 3'h0 |-> !irq_n)
    else $error("source code shown without interrupt");
  AST_IRQ_HOLD: assert property ($rose(irq_n) |-> $past(bus_req.wr, 2))
    else $error("interrupt released without a host write");
  AST_TX0_RAISE: assert property (events.tx_empty[0] && en_q[2] && !bus_req.wr
    |-> ##2 !irq_n)
    else $error("tx empty did not interrupt");
  AST_RX1_CODE: assert property (events.rx_loaded[1] && en_q[1] && !bus_req.wr
    |-> ##2 irq_source_code != 3'h0)
    else $error("rx loaded gave no source code");
  AST_MERR_RAISE: assert property (events.msg_fault && en_q[7] && !bus_req.wr
    |-> ##2 !irq_n)
    else $error("message fault did not interrupt");
  AST_OVR_RAISE: assert property (events.rx_overrun[0] && en_q[5] && !bus_req.wr
    |-> ##[2:3] !irq_n)
    else $error("overrun did not interrupt");
  AST_WAKE: assert property (sleeping && events.bus_activity && en_q[6] && !bus_req.wr
    |-> ##2 (!irq_n && !sleeping))
    else $error("wake did not interrupt or leave sleep");
endmodule : cniu_top_sva

bind cniu_top cniu_top_sva u_sva (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
  .rd_data(rd_data), .events(events), .sleeping(sleeping), .irq_n(irq_n),
  .irq_source_code(irq_source_code));

// ### verification/cniu_host_model.sv
// host model driving the register port of the interrupt unit
`timescale 1ns/10ps

module cniu_host_model
  import cniu_pkg::*;
(
  input wire logic clk, // device clock
  output cniu_pkg::cniu_bus_req_t bus_req, // register port request
  input wire logic [7:0] rd_data // read data from the device
);
  import cniu_pkg::*;
  initial bus_req = '0;
  // idle address and data are inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    bus_req.addr <= ~a;
    bus_req.wdata <= ~d;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    bus_req.addr <= ~a;
    @(posedge clk);
  endtask : rd
  // only the masked bits change; a hardware set landing between read and write is lost
  task automatic modify(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    logic [7:0] cur;
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    cur = rd_data;
    @(posedge clk);
    wr(a, (cur & ~m) | (v & m));
  endtask : modify
endmodule : cniu_host_model

// ### verification/cniu_top_tb.sv
// self-checking bench for the can node interrupt unit
`timescale 1ns/10ps
`include "cniu_consts.svh"

module cniu_top_tb;
  import cniu_pkg::*;
  logic clk, reset_n, sleep_request, sleeping, irq_n, rd_q = 1'b0;
  cniu_bus_req_t bus_req;
  cniu_events_t events;
  cniu_hold_t hold;
  logic [8:0] tx_err_count, rx_err_count;
  logic [7:0] rd_data, f, e, m, pf;
  logic [2:0] irq_source_code;
  logic [15:0] expq[$];
  logic [15:0] ent;
  int failures, checks_done, i, k;
  int seed = 32'h197d;
  int bpos[8] = '{0, 5, 6, 2, 3, 4, 0, 1};
  logic [8:0] evv[3] = '{9'h020, 9'h002, 9'h004};
  logic [7:0] flv[3] = '{8'h02, 8'h80, 8'h20};
  logic [2:0] cdv[3] = '{3'h7, 3'h0, 3'h1};
  logic [8:0] txv[7] = '{9'h05f, 9'h060, 9'h07f, 9'h080, 9'h0ff, 9'h100, 9'h100};
  logic [8:0] rxv[7] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h080};
  logic [7:0] fv[7] = '{8'h00, 8'h05, 8'h05, 8'h15, 8'h15, 8'h35, 8'h3f};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  cniu_top u_dut (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data),
    .events(events), .hold(hold), .tx_err_count(tx_err_count), .rx_err_count(rx_err_count),
    .sleep_request(sleep_request), .sleeping(sleeping), .irq_n(irq_n),
    .irq_source_code(irq_source_code));
  cniu_host_model u_host (.clk(clk), .bus_req(bus_req), .rd_data(rd_data));

  function automatic logic [2:0] top(input logic [7:0] p);
    top = p[5] ? 3'h1 : p[6] ? 3'h2 : p[2] ? 3'h3 : p[3] ? 3'h4 : p[4] ? 3'h5 :
      p[0] ? 3'h6 : p[1] ? 3'h7 : 3'h0;
  endfunction : top
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] mk);
    expq.push_back({mk, x});
    u_host.rd(a);
  endtask : rd
  task automatic mod(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] v);
    expq.push_back(16'h0000);
    u_host.modify(a, mk, v);
  endtask : mod
  task automatic pin(input logic ei, input logic [2:0] ec);
    @(negedge clk);
    chk({7'h00, irq_n}, {7'h00, ei});
    chk({5'h00, irq_source_code}, {5'h00, ec});
    @(posedge clk);
  endtask : pin
  task automatic ev(input logic [8:0] v);
    events <= v;
    @(posedge clk);
    events <= '0;
    @(posedge clk);
  endtask : ev
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // read answers are taken mid-cycle, away from the edge that clears them
  always @(posedge clk) rd_q <= bus_req.rd;
  always @(negedge clk) begin
    if (rd_q) begin
      ent = expq.pop_front();
      chk(rd_data & ent[15:8], ent[7:0] & ent[15:8]);
    end
  end
  // a full run is well under a thousand cycles, so this leaves a wide margin
  initial begin
    #300000;
    failures++;
    test_done();
  end
  initial begin
    events = '0;
    hold = '0;
    tx_err_count = 9'h000;
    rx_err_count = 9'h000;
    sleep_request = 1'b0;
    reset_n = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    pin(1'b1, 3'h0);
    rd(`CNIU_OFS_ENABLE, 8'h00, 8'hff);
    rd(`CNIU_OFS_FLAG, 8'h00, 8'hff);
    rd(8'h55, 8'h00, 8'hff);
    u_host.wr(`CNIU_OFS_ENABLE, 8'hff);
    for (i = 0; i < 8; i++) begin
      u_host.wr(`CNIU_OFS_FLAG, 8'h01 << i);
      pin(1'b0, top(8'h01 << i));
      u_host.wr(`CNIU_OFS_FLAG, 8'h00);
      pin(1'b1, 3'h0);
    end
    $display("test reset and codes done");
    for (i = 0; i < 6; i++) begin
      f = 8'($random(seed));
      e = 8'($random(seed));
      u_host.wr(`CNIU_OFS_ENABLE, e);
      u_host.wr(`CNIU_OFS_FLAG, f);
      rd(`CNIU_OFS_FLAG, f, 8'hff);
      for (k = 0; k < 8; k++) begin
        rd(`CNIU_OFS_STATUS, {top(f & e), 5'h00}, 8'he1);
        pin(~|(f & e), top(f & e));
        m = 8'h01 << bpos[top(f & e)];
        if (top(f & e) != 3'h0) begin
          f = f & ~m;
          mod(`CNIU_OFS_FLAG, m, 8'h00);
        end
      end
      u_host.wr(`CNIU_OFS_FLAG, 8'h00);
    end
    $display("test priority done");
    u_host.wr(`CNIU_OFS_ENABLE, 8'h04);
    hold <= 5'h04;
    ev(9'h040);
    pin(1'b0, 3'h3);
    mod(`CNIU_OFS_FLAG, 8'h04, 8'h00);
    rd(`CNIU_OFS_FLAG, 8'h04, 8'hff);
    hold <= 5'h00;
    mod(`CNIU_OFS_FLAG, 8'h04, 8'h00);
    pin(1'b1, 3'h0);
    u_host.wr(`CNIU_OFS_ENABLE, 8'hff);
    for (i = 0; i < 3; i++) begin
      ev(evv[i]);
      rd(`CNIU_OFS_FLAG, flv[i], 8'hff);
      pin(1'b0, cdv[i]);
      if (i == 2) begin
        mod(`CNIU_OFS_FLAG, 8'h20, 8'h00);
        rd(`CNIU_OFS_FLAG, 8'h20, 8'hff);
        rd(`CNIU_OFS_FAULT, 8'h40, 8'hff);
        mod(`CNIU_OFS_FAULT, 8'h40, 8'h00);
      end
      mod(`CNIU_OFS_FLAG, flv[i], 8'h00);
      pin(1'b1, 3'h0);
    end
    $display("test events done");
    pf = 8'h00;
    for (i = 0; i < 7; i++) begin
      tx_err_count <= txv[i];
      rx_err_count <= rxv[i];
      repeat (4) @(posedge clk);
      rd(`CNIU_OFS_FAULT, fv[i], 8'h3f);
      rd(`CNIU_OFS_TXCNT, txv[i][7:0], 8'hff);
      rd(`CNIU_OFS_RXCNT, rxv[i][7:0], 8'hff);
      pin(fv[i] == pf, (fv[i] == pf) ? 3'h0 : 3'h1);
      mod(`CNIU_OFS_FLAG, 8'h20, 8'h00);
      pf = fv[i];
    end
    tx_err_count <= 9'h000;
    rx_err_count <= 9'h000;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(`CNIU_OFS_FLAG, 8'h00, 8'hff);
    pin(1'b1, 3'h0);
    $display("test error states done");
    u_host.wr(`CNIU_OFS_ENABLE, 8'h40);
    sleep_request <= 1'b1;
    repeat (3) @(posedge clk);
    sleep_request <= 1'b0;
    rd(`CNIU_OFS_STATUS, 8'h01, 8'h01);
    ev(9'h001);
    pin(1'b0, 3'h2);
    // sampled mid-cycle, away from the edge that moves the sleep state
    @(negedge clk);
    chk({7'h00, sleeping}, 8'h00);
    @(posedge clk);
    mod(`CNIU_OFS_FLAG, 8'h40, 8'h00);
    pin(1'b1, 3'h0);
    $display("test wake done");
    test_done();
  end
endmodule : cniu_top_tb
